// ==== inc/eom_pkg.sv ====
package eom_pkg;
   // special function register addresses and reset values
   localparam logic [7:0] EXT_OSC_CONTROL_ADDR          = 8'h9F;
   localparam logic [7:0] CLOCK_MULTIPLIER_CONTROL_ADDR = 8'h97;
   localparam logic [7:0] EXT_OSC_CONTROL_RESET         = 8'h00;
   localparam logic [7:0] CLOCK_MULTIPLIER_CONTROL_RESET = 8'h00;
   // ext_osc_control fields
   localparam int CRYSTAL_VALID_BIT = 7;
   localparam int EXT_OSC_MODE_LSB  = 4;
   localparam int EXT_OSC_FREQ_LSB  = 0;
   // clock_multiplier_control fields
   localparam int MULT_ENABLE_BIT     = 7;
   localparam int MULT_INITIALIZE_BIT = 6;
   localparam int MULT_LOCKED_BIT     = 5;
   localparam int MULT_SCALE_LSB      = 2;
   localparam int MULT_SELECT_LSB     = 0;
   // oscillator mode codes
   localparam logic [2:0] MODE_OFF        = 3'h0;
   localparam logic [2:0] MODE_OFF_ALT    = 3'h1;
   localparam logic [2:0] MODE_CMOS       = 3'h2;
   localparam logic [2:0] MODE_CMOS_DIV2  = 3'h3;
   localparam logic [2:0] MODE_RC         = 3'h4;
   localparam logic [2:0] MODE_CAP        = 3'h5;
   localparam logic [2:0] MODE_XTAL       = 3'h6;
   localparam logic [2:0] MODE_XTAL_DIV2  = 3'h7;
   // multiplier input select codes and the unity scale code
   localparam logic [1:0] SEL_INT_X2 = 2'h0;
   localparam logic [1:0] SEL_EXT_X2 = 2'h1;
   localparam logic [1:0] SEL_INT_X4 = 2'h2;
   localparam logic [1:0] SEL_EXT_X4 = 2'h3;
   localparam logic [2:0] SCALE_NONE = 3'h0;
   // multiplier lock wait
   localparam int LOCK_TIME_US = 5;
   localparam int CLOCK_MHZ    = 40;
   localparam int LOCK_CYCLES  = LOCK_TIME_US * CLOCK_MHZ;
   typedef enum logic [1:0] {OSC_SRC_NONE, OSC_SRC_CMOS, OSC_SRC_RC_CAP, OSC_SRC_XTAL} eom_src_type;
endpackage

// ==== inc/eom_mode_if.sv ====
`timescale 1ns/1ps
interface eom_mode_if;
   logic [2:0]           mode;
   eom_pkg::eom_src_type src;
   logic                 div2;
   logic                 is_crystal;
   modport decoder (input mode, output src, output div2, output is_crystal);
   modport user    (output mode, input src, input div2, input is_crystal);
endinterface

// ==== src/eom_mode_decode.sv ====
`timescale 1ns/1ps
module eom_mode_decode
(
   eom_mode_if.decoder m
);
   always_comb
   begin
      m.src        = eom_pkg::OSC_SRC_NONE;
      m.div2       = 1'b0;
      m.is_crystal = 1'b0;
      unique case (m.mode)
         eom_pkg::MODE_OFF, eom_pkg::MODE_OFF_ALT:
         begin
            m.src = eom_pkg::OSC_SRC_NONE;
         end
         eom_pkg::MODE_CMOS:
         begin
            m.src = eom_pkg::OSC_SRC_CMOS;
         end
         eom_pkg::MODE_CMOS_DIV2:
         begin
            m.src  = eom_pkg::OSC_SRC_CMOS;
            m.div2 = 1'b1;
         end
         eom_pkg::MODE_RC, eom_pkg::MODE_CAP:
         begin
            m.src = eom_pkg::OSC_SRC_RC_CAP;
         end
         eom_pkg::MODE_XTAL:
         begin
            m.src        = eom_pkg::OSC_SRC_XTAL;
            m.is_crystal = 1'b1;
         end
         eom_pkg::MODE_XTAL_DIV2:
         begin
            m.src        = eom_pkg::OSC_SRC_XTAL;
            m.div2       = 1'b1;
            m.is_crystal = 1'b1;
         end
      endcase
   end
endmodule // eom_mode_decode

// ==== src/eom_ext_osc_mult.sv ====
`timescale 1ns/1ps
// Functional notes
// - the select field picks internal or external source times two or four; only internal times two forces unity scaling.
// - internal times two ignores the output scaling field.
// - crystal valid is read only, zero unless a crystal mode runs stably.
// - mode field bits 6:4 choose off, cmos, cmos halved, rc, capacitor, crystal, crystal halved.
// - crystal mode takes pins P0.2 and P0.3.
// - capacitor, rc and cmos modes take only pin P0.3.
module eom_ext_osc_mult
#(
   parameter int LOCK_WAIT = eom_pkg::LOCK_CYCLES
)
(
   input  wire logic       CLOCK,
   input  wire logic       RESET,
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic       SFR_WR,
   input  wire logic       SFR_RD,
   input  wire logic [7:0] SFR_WDATA,
   output logic      [7:0] SFR_RDATA,
   input  wire logic       OSC_STABLE,
   output logic            OSC_DRIVE_EN,
   output logic      [2:0] OSC_FREQ_CTRL,
   output logic            OSC_DIV2,
   output logic            PIN_P02_TAKEN,
   output logic            PIN_P03_TAKEN,
   output logic            MULT_SRC_EXT,
   output logic            MULT_X4,
   output logic      [2:0] MULT_SCALE_EFF,
   output logic            MULT_ENABLE,
   output logic            MULT_LOCKED
);
   typedef struct packed {
      logic [2:0] mode;
      logic [2:0] freq;
      logic       stable_s1;
      logic       stable_s2;
      logic       mult_en;
      logic       mult_init;
      logic       mult_lock;
      logic [2:0] mult_scale;
      logic [1:0] mult_sel;
      logic [15:0] lock_cnt;
      logic       locking;
      logic [7:0] rdata;
   } eom_state_type;

   eom_state_type st_r;
   eom_state_type st_nxt;
   eom_mode_if    mif ();

   assign mif.mode = st_r.mode;

   eom_mode_decode u_dec
   (
      .m (mif.decoder)
   );

   logic       xtal_valid;
   logic [7:0] osc_reg_val;
   logic [7:0] mul_reg_val;

   always_comb
   begin
      // first stage of the synchroniser only feeds the second
      xtal_valid  = mif.is_crystal & st_r.stable_s2;
      osc_reg_val = {xtal_valid, st_r.mode, 1'b0, st_r.freq};
      mul_reg_val = {st_r.mult_en, st_r.mult_init, st_r.mult_lock, st_r.mult_scale, st_r.mult_sel};
      st_nxt           = st_r;
      st_nxt.stable_s1 = OSC_STABLE;
      st_nxt.stable_s2 = st_r.stable_s1;
      if (SFR_WR && SFR_ADDR == eom_pkg::EXT_OSC_CONTROL_ADDR)
      begin
         st_nxt.mode = SFR_WDATA[eom_pkg::EXT_OSC_MODE_LSB +: 3];
         st_nxt.freq = SFR_WDATA[eom_pkg::EXT_OSC_FREQ_LSB +: 3];
      end
      if (SFR_WR && SFR_ADDR == eom_pkg::CLOCK_MULTIPLIER_CONTROL_ADDR)
      begin
         st_nxt.mult_en    = SFR_WDATA[eom_pkg::MULT_ENABLE_BIT];
         st_nxt.mult_scale = SFR_WDATA[eom_pkg::MULT_SCALE_LSB +: 3];
         st_nxt.mult_sel   = SFR_WDATA[eom_pkg::MULT_SELECT_LSB +: 2];
         // init only takes effect once enabled; it restarts lock
         st_nxt.mult_init  = SFR_WDATA[eom_pkg::MULT_INITIALIZE_BIT] & st_r.mult_en;
         if (SFR_WDATA[eom_pkg::MULT_INITIALIZE_BIT] && st_r.mult_en && SFR_WDATA[eom_pkg::MULT_ENABLE_BIT])
         begin
            st_nxt.locking   = 1'b1;
            st_nxt.lock_cnt  = 16'h0000;
            st_nxt.mult_lock = 1'b0;
         end
         if (!SFR_WDATA[eom_pkg::MULT_ENABLE_BIT])
         begin
            st_nxt.locking   = 1'b0;
            st_nxt.mult_lock = 1'b0;
            st_nxt.mult_init = 1'b0;
         end
      end
      else if (st_r.locking)
      begin
         // lock is modelled as a fixed settle count, not a real phase detector
         if (st_r.lock_cnt >= 16'(LOCK_WAIT - 1))
         begin
            st_nxt.locking   = 1'b0;
            st_nxt.mult_lock = 1'b1;
         end
         else
         begin
            st_nxt.lock_cnt = st_r.lock_cnt + 16'h0001;
         end
      end
      st_nxt.rdata = 8'h00;
      if (SFR_RD && SFR_ADDR == eom_pkg::EXT_OSC_CONTROL_ADDR)
      begin
         st_nxt.rdata = osc_reg_val;
      end
      else if (SFR_RD && SFR_ADDR == eom_pkg::CLOCK_MULTIPLIER_CONTROL_ADDR)
      begin
         st_nxt.rdata = mul_reg_val;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   always_comb
   begin
      SFR_RDATA      = st_r.rdata;
      OSC_DRIVE_EN   = mif.src != eom_pkg::OSC_SRC_NONE;
      OSC_FREQ_CTRL  = st_r.freq;
      OSC_DIV2       = mif.div2;
      PIN_P02_TAKEN  = mif.src == eom_pkg::OSC_SRC_XTAL;
      PIN_P03_TAKEN  = OSC_DRIVE_EN;
      MULT_SRC_EXT   = st_r.mult_sel[0];
      MULT_X4        = st_r.mult_sel[1];
      MULT_SCALE_EFF = (st_r.mult_sel == eom_pkg::SEL_INT_X2) ? eom_pkg::SCALE_NONE : st_r.mult_scale;
      MULT_ENABLE    = st_r.mult_en;
      MULT_LOCKED    = st_r.mult_lock;
   end
endmodule // eom_ext_osc_mult

// ==== tb/eom_chk.sv ====
`timescale 1ns/1ps
module eom_chk
(
   input wire logic       CLOCK,
   input wire logic       RESET,
   input wire logic [7:0] SFR_ADDR,
   input wire logic       SFR_WR,
   input wire logic       SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       OSC_DRIVE_EN,
   input wire logic [2:0] OSC_FREQ_CTRL,
   input wire logic       OSC_DIV2,
   input wire logic       PIN_P02_TAKEN,
   input wire logic       PIN_P03_TAKEN,
   input wire logic       MULT_SRC_EXT,
   input wire logic       MULT_X4,
   input wire logic [2:0] MULT_SCALE_EFF
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   sequence osc_wr; SFR_WR && SFR_ADDR == 8'h9F; endsequence
   sequence osc_rd; SFR_RD && SFR_ADDR == 8'h9F; endsequence
   sequence mul_wr; SFR_WR && SFR_ADDR == 8'h97; endsequence
   a_sel_decode: assert property (mul_wr |=> {MULT_X4, MULT_SRC_EXT} == $past(SFR_WDATA[1:0]))
      else $error("select wrong");
   a_scale_ignored: assert property (!MULT_X4 && !MULT_SRC_EXT |-> MULT_SCALE_EFF == 3'h0)
      else $error("scale not ignored");
   a_valid_mode: assert property ((osc_rd and !PIN_P02_TAKEN) |=> !SFR_RDATA[7])
      else $error("valid outside crystal");
   a_mode_div2: assert property (osc_wr |=> OSC_DIV2 == ($past(SFR_WDATA[5:4]) == 2'h3))
      else $error("halving wrong");
   a_freq_field: assert property (osc_wr |=> OSC_FREQ_CTRL == $past(SFR_WDATA[2:0]))
      else $error("freq field wrong");
   a_xtal_pins: assert property (osc_wr |=> PIN_P02_TAKEN == ($past(SFR_WDATA[6:5]) == 2'h3))
      else $error("crystal pins wrong");
   a_one_pin: assert property (osc_wr |=> PIN_P03_TAKEN == ($past(SFR_WDATA[6:5]) != 2'h0)
      && OSC_DRIVE_EN == PIN_P03_TAKEN) else $error("input pin wrong");
   a_bit3_zero: assert property (osc_rd |=> !SFR_RDATA[3])
      else $error("unused bit set");
endmodule // eom_chk

// ==== tb/eom_osc_model.sv ====
`timescale 1ns/1ps
module eom_osc_model
(
   input  wire logic CLOCK,
   input  wire logic PIN_P02_TAKEN,
   output logic      OSC_STABLE
);
   int cnt = 0;
   // amplitude builds only while both crystal pins are held
   always @(posedge CLOCK) cnt <= PIN_P02_TAKEN ? cnt + 1 : 0;
   assign OSC_STABLE = cnt > 40;
endmodule // eom_osc_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic       CLOCK = 0, RESET = 1, SFR_WR = 0, SFR_RD = 0, OSC_STABLE;
   logic [7:0] SFR_ADDR = 0, SFR_WDATA = 0, SFR_RDATA;
   logic       OSC_DRIVE_EN, OSC_DIV2, PIN_P02_TAKEN, PIN_P03_TAKEN;
   logic       MULT_SRC_EXT, MULT_X4, MULT_ENABLE, MULT_LOCKED;
   logic [2:0] OSC_FREQ_CTRL, MULT_SCALE_EFF;
   int         errors = 0, checks_done = 0;
   always #12.5 CLOCK = ~CLOCK;
   eom_ext_osc_mult #(.LOCK_WAIT(4)) dut_u (.CLOCK(CLOCK), .RESET(RESET), .SFR_ADDR(SFR_ADDR),
      .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .OSC_STABLE(OSC_STABLE),
      .OSC_DRIVE_EN(OSC_DRIVE_EN), .OSC_FREQ_CTRL(OSC_FREQ_CTRL), .OSC_DIV2(OSC_DIV2),
      .PIN_P02_TAKEN(PIN_P02_TAKEN), .PIN_P03_TAKEN(PIN_P03_TAKEN), .MULT_SRC_EXT(MULT_SRC_EXT),
      .MULT_X4(MULT_X4), .MULT_SCALE_EFF(MULT_SCALE_EFF), .MULT_ENABLE(MULT_ENABLE), .MULT_LOCKED(MULT_LOCKED));
   eom_osc_model osc_u (.CLOCK(CLOCK), .PIN_P02_TAKEN(PIN_P02_TAKEN), .OSC_STABLE(OSC_STABLE));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      SFR_ADDR = a;
      SFR_WDATA = d;
      SFR_WR = 1;
      @(negedge CLOCK);
      SFR_WR = 0;
      @(negedge CLOCK);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      SFR_ADDR = a;
      SFR_RD = 1;
      @(negedge CLOCK);
      SFR_RD = 0;
      chk(SFR_RDATA, e);
      @(negedge CLOCK);
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge CLOCK);
      RESET = 0;
      rd(8'h9F, 8'h00);
      rd(8'h97, 8'h00);
      rd(8'h55, 8'h00);
      $display("reset test done");
      for (int m = 0; m < 8; m++)
      begin
         wr(8'h9F, {1'h1, m[2:0], 4'hD});
         chk(OSC_DIV2, m == 3 || m == 7);
         chk(PIN_P02_TAKEN, m >= 6);
         chk({OSC_DRIVE_EN, PIN_P03_TAKEN}, {2{m >= 2}});
         chk(OSC_FREQ_CTRL, 3'h5);
         rd(8'h9F, {1'h0, m[2:0], 4'h5});
      end
      $display("mode test done");
      wr(8'h9F, 8'h67);
      // roughly 1 ms of settling before the first poll of crystal valid
      repeat (40000) @(negedge CLOCK);
      rd(8'h9F, 8'hE7);
      wr(8'h9F, 8'hC7);
      rd(8'h9F, 8'h47);
      $display("crystal test done");
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h97, {6'h05, s[1:0]});
         chk({MULT_X4, MULT_SRC_EXT}, s[1:0]);
         chk(MULT_SCALE_EFF, s == 0 ? 3'h0 : 3'h5);
      end
      wr(8'h97, 8'h80);
      // more than 5 us between enable and initialize
      repeat (eom_pkg::LOCK_CYCLES) @(negedge CLOCK);
      wr(8'h97, 8'hC0);
      rd(8'h97, 8'hC0);
      repeat (7) @(negedge CLOCK);
      chk({MULT_ENABLE, MULT_LOCKED}, 2'h3);
      rd(8'h97, 8'hE0);
      wr(8'h97, 8'h00);
      chk(MULT_LOCKED, 1'h0);
      $display("multiplier test done");
      finish_test;
   end
   initial
   begin
      #1500000;
      errors++;
      finish_test;
   end
endmodule // testbench
bind eom_ext_osc_mult eom_chk chk_u (.CLOCK(CLOCK), .RESET(RESET), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
   .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .OSC_DRIVE_EN(OSC_DRIVE_EN),
   .OSC_FREQ_CTRL(OSC_FREQ_CTRL), .OSC_DIV2(OSC_DIV2), .PIN_P02_TAKEN(PIN_P02_TAKEN), .PIN_P03_TAKEN(PIN_P03_TAKEN),
   .MULT_SRC_EXT(MULT_SRC_EXT), .MULT_X4(MULT_X4), .MULT_SCALE_EFF(MULT_SCALE_EFF));
